// ### design/fbp_pkg.sv
// Package of constants and types for the flash byte bus host controller.
package fbp_pkg;

   // ----------------------------------------
   // Bus widths
   // ----------------------------------------
   localparam int FBP_ADDR_W = 18;
   localparam int FBP_DATA_W = 8;

   // ----------------------------------------
   // Timing, in ns as specified, and derived cycle counts at 50 ns
   // ----------------------------------------
   localparam int FBP_CLK_NS = 50;
   // Read access allowance, a least time, so it rounds up.
   localparam int FBP_T_READ_NS = 150;
   localparam logic [3:0] FBP_READ_CYC = 4'((FBP_T_READ_NS + FBP_CLK_NS - 1) / FBP_CLK_NS);
   // Write strobe low width, a least time.
   localparam int FBP_T_WPULSE_NS = 100;
   localparam logic [3:0] FBP_WPULSE_CYC =
      4'((FBP_T_WPULSE_NS + FBP_CLK_NS - 1) / FBP_CLK_NS);
   // Setup and hold around strobes, a least time.
   localparam int FBP_T_SETUP_NS = 50;
   localparam logic [3:0] FBP_SETUP_CYC = 4'((FBP_T_SETUP_NS + FBP_CLK_NS - 1) / FBP_CLK_NS);

   // ----------------------------------------
   // Request kinds and controller states
   // ----------------------------------------
   typedef enum logic [1:0]
   {
      FBP_OP_READ = 2'b00,
      FBP_OP_WRITE = 2'b01,
      FBP_OP_PROGRAM = 2'b10,
      FBP_OP_SIGNATURE = 2'b11
   } fbp_op_t;

   typedef enum logic [2:0]
   {
      FBP_ST_IDLE = 3'b000,
      FBP_ST_SETUP = 3'b001,
      FBP_ST_STROBE = 3'b010,
      FBP_ST_HOLD = 3'b011,
      FBP_ST_READ = 3'b100,
      FBP_ST_DONE = 3'b101
   } fbp_state_t;

   // Second write of a program sequence carries the array data.
   localparam logic FBP_SECOND_CYCLE = 1'b1;

endpackage

// ### design/fbp_host.sv
// Host controller that drives a byte-wide boot-block flash over its pins.
`timescale 1ns/10ps
// ----------------------------------------
// Behaviour
// - Host requests high voltage on address line nine to enter signature mode.
// - Program: host sends setup write, then array data on second write cycle.
// - Host raises reset/power-down to unlock level for boot block work.
// - Device latches on strobe rising edge; host holds address and data across it.
// ----------------------------------------
module fbp_host
(
   // Clock and reset.
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   // User request side.
   input wire logic i_req,
   input wire fbp_pkg::fbp_op_t i_op,
   input wire logic [fbp_pkg::FBP_ADDR_W-1:0] i_addr,
   input wire logic [fbp_pkg::FBP_DATA_W-1:0] i_wdata,
   input wire logic [fbp_pkg::FBP_DATA_W-1:0] i_cmd,
   input wire logic i_boot_unlock,
   input wire logic i_powerdown,
   output logic o_busy,
   output logic o_done,
   output logic [fbp_pkg::FBP_DATA_W-1:0] o_rdata,
   // Flash pins.
   output logic [fbp_pkg::FBP_ADDR_W-1:0] o_addr_in,
   output logic o_addr_line_nine_signature_sel,
   output logic [fbp_pkg::FBP_DATA_W-1:0] o_data_io,
   output logic o_data_io_oe_n,
   input wire logic [fbp_pkg::FBP_DATA_W-1:0] i_data_io,
   output logic o_chip_sel_n,
   output logic o_out_en_n,
   output logic o_write_strobe_n,
   output logic o_reset_powerdown_n,
   output logic o_reset_powerdown_unlock
);
   import fbp_pkg::*;

   // ----------------------------------------
   // State
   // ----------------------------------------
   fbp_state_t state;
   fbp_state_t next_state;
   fbp_op_t op;
   logic [3:0] cnt;
   logic [3:0] next_cnt;
   logic second;
   logic [FBP_DATA_W-1:0] wdata;
   logic [FBP_DATA_W-1:0] cmd;

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   // A program sequence runs the write cycle twice: command, then array data.
   wire is_prog = (op == FBP_OP_PROGRAM);
   wire is_wr = (op == FBP_OP_WRITE) || is_prog;
   wire cnt_done = (cnt == 4'h0);
   wire take = (state == FBP_ST_IDLE) && i_req && !i_powerdown;
   wire need_second = is_prog && (second != FBP_SECOND_CYCLE);
   wire [FBP_DATA_W-1:0] bus_byte = (is_prog && second) ? wdata : cmd;
   wire [FBP_DATA_W-1:0] out_byte = (op == FBP_OP_WRITE) ? cmd : bus_byte;

   // Next state logic; counts are loaded minus one so each phase lasts its count.
   always_comb
   begin
      next_state = state;
      next_cnt = cnt;
      unique case (state)
         FBP_ST_IDLE:
         begin
            if (take)
            begin
               next_state = FBP_ST_SETUP;
               next_cnt = FBP_SETUP_CYC - 4'h1;
            end
         end
         FBP_ST_SETUP:
         begin
            if (!cnt_done)
               next_cnt = cnt - 4'h1;
            else if (is_wr)
            begin
               next_state = FBP_ST_STROBE;
               next_cnt = FBP_WPULSE_CYC - 4'h1;
            end
            else
            begin
               next_state = FBP_ST_READ;
               next_cnt = FBP_READ_CYC - 4'h1;
            end
         end
         FBP_ST_STROBE:
         begin
            if (!cnt_done)
               next_cnt = cnt - 4'h1;
            else
            begin
               next_state = FBP_ST_HOLD;
               next_cnt = FBP_SETUP_CYC - 4'h1;
            end
         end
         FBP_ST_HOLD:
         begin
            if (!cnt_done)
               next_cnt = cnt - 4'h1;
            else if (need_second)
            begin
               next_state = FBP_ST_SETUP;
               next_cnt = FBP_SETUP_CYC - 4'h1;
            end
            else
               next_state = FBP_ST_DONE;
         end
         FBP_ST_READ:
         begin
            if (!cnt_done)
               next_cnt = cnt - 4'h1;
            else
               next_state = FBP_ST_DONE;
         end
         FBP_ST_DONE:
            next_state = FBP_ST_IDLE;
         default:
            next_state = FBP_ST_IDLE;
      endcase
   end

   // ----------------------------------------
   // Sequencer registers
   // ----------------------------------------
   // Request fields are captured once so pins stay steady for the whole cycle.
   always_ff @(posedge i_sys_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         state <= FBP_ST_IDLE;
         cnt <= 4'h0;
         op <= FBP_OP_READ;
         wdata <= 8'h00;
         cmd <= 8'h00;
      end
      else
      begin
         state <= next_state;
         cnt <= next_cnt;
         if (take)
         begin
            op <= i_op;
            wdata <= i_wdata;
            cmd <= i_cmd;
         end
      end
   end

   // Tracks which write of a program pair is on the bus.
   always_ff @(posedge i_sys_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         second <= 1'b0;
      else if (take)
         second <= 1'b0;
      else if (state == FBP_ST_HOLD && cnt_done && need_second)
         second <= FBP_SECOND_CYCLE;
   end

   // ----------------------------------------
   // Pin drive
   // ----------------------------------------
   // Chip select spans setup to hold so the strobe pulse always sits inside it.
   wire sel_phase = (state == FBP_ST_SETUP) || (state == FBP_ST_STROBE) ||
      (state == FBP_ST_HOLD) || (state == FBP_ST_READ);
   wire next_sel = (next_state == FBP_ST_SETUP) || (next_state == FBP_ST_STROBE) ||
      (next_state == FBP_ST_HOLD) || (next_state == FBP_ST_READ);
   wire next_oe = (next_state == FBP_ST_READ) || ((next_state == FBP_ST_SETUP) && !is_wr
      && (state != FBP_ST_IDLE));
   wire next_we = (next_state == FBP_ST_STROBE);
   // On the take edge the op register still holds the last request, so look at the new one.
   // Otherwise a write would start undriven and a read after a write would drive in setup.
   wire next_is_wr = take ? ((i_op == FBP_OP_WRITE) || (i_op == FBP_OP_PROGRAM)) : is_wr;
   wire next_drive = next_sel && next_is_wr;

   always_ff @(posedge i_sys_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         o_chip_sel_n <= 1'b1;
         o_out_en_n <= 1'b1;
         o_write_strobe_n <= 1'b1;
         o_data_io_oe_n <= 1'b1;
      end
      else
      begin
         o_chip_sel_n <= !next_sel;
         o_out_en_n <= !(next_oe && !next_we);
         o_write_strobe_n <= !next_we;
         o_data_io_oe_n <= !next_drive;
      end
   end

   // Address and data stay put from setup through hold, across the strobe rise.
   always_ff @(posedge i_sys_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         o_addr_in <= 18'h00000;
         o_data_io <= 8'h00;
         o_addr_line_nine_signature_sel <= 1'b0;
      end
      else if (state == FBP_ST_IDLE && take)
      begin
         o_addr_in <= i_addr;
         o_data_io <= i_cmd;
         o_addr_line_nine_signature_sel <= (i_op == FBP_OP_SIGNATURE);
      end
      else if (state == FBP_ST_HOLD && cnt_done && need_second)
         o_data_io <= wdata;
      else if (state == FBP_ST_DONE)
         o_addr_line_nine_signature_sel <= 1'b0;
      else if (!sel_phase)
         o_data_io <= out_byte;
   end

   // Read data is sampled on the last cycle of the access window.
   always_ff @(posedge i_sys_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         o_rdata <= 8'h00;
      else if (state == FBP_ST_READ && cnt_done)
         o_rdata <= i_data_io;
   end

   // ----------------------------------------
   // Status and reset/power-down control
   // ----------------------------------------
   // Unlock level is only requested while the pin is high; low already locks.
   always_ff @(posedge i_sys_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         o_busy <= 1'b0;
         o_done <= 1'b0;
         o_reset_powerdown_n <= 1'b0;
         o_reset_powerdown_unlock <= 1'b0;
      end
      else
      begin
         o_busy <= (next_state != FBP_ST_IDLE);
         o_done <= (state == FBP_ST_DONE);
         o_reset_powerdown_n <= !i_powerdown || (state != FBP_ST_IDLE);
         o_reset_powerdown_unlock <= i_boot_unlock && !i_powerdown;
      end
   end

endmodule

// ### tb/fbp_sva.sv
// Checker of the pin timing that the flash host controller drives.
`timescale 1ns/10ps
module fbp_sva
(
   // Clock, reset and user control.
   input logic i_sys_clk,
   input logic i_sys_rst,
   input logic i_powerdown,
   input logic o_busy,
   // Flash pins.
   input logic [17:0] o_addr_in,
   input logic o_addr_line_nine_signature_sel,
   input logic [7:0] o_data_io,
   input logic o_data_io_oe_n,
   input logic o_chip_sel_n,
   input logic o_out_en_n,
   input logic o_write_strobe_n,
   input logic o_reset_powerdown_n
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);
   // A read and a write must never overlap, or the two sides fight on the data pins.
   oe_we_excl_a: assert property (!(!o_out_en_n && !o_write_strobe_n))
      else $error("output enable and write strobe low together");
   we_in_cs_a: assert property (!o_write_strobe_n |-> !o_chip_sel_n)
      else $error("write strobe low while deselected");
   we_width_a: assert property ($fell(o_write_strobe_n) |=> !o_write_strobe_n ##1 o_write_strobe_n)
      else $error("write strobe pulse not two cycles");
   addr_hold_a: assert property (!o_write_strobe_n |=> $stable(o_addr_in) && $stable(o_data_io))
      else $error("address or data moved across strobe");
   drive_wr_a: assert property (!o_write_strobe_n |-> !o_data_io_oe_n)
      else $error("data not driven during write strobe");
   no_drive_rd_a: assert property (!o_out_en_n |-> o_data_io_oe_n)
      else $error("host drives data during read");
   // A transfer in flight finishes first; the pin drops once the sequencer is idle.
   pd_pin_a: assert property (i_powerdown && !o_busy |=> !o_reset_powerdown_n)
      else $error("power-down pin not low");
   sig_nowr_a: assert property (o_addr_line_nine_signature_sel |-> o_write_strobe_n)
      else $error("write during signature request");
   read_len_a: assert property ($fell(o_out_en_n) |=> !o_out_en_n [*2] ##1 o_out_en_n)
      else $error("read window not three cycles");
   cover property ($fell(o_write_strobe_n));
   cover property ($fell(o_out_en_n));
   cover property ($rose(o_addr_line_nine_signature_sel));
endmodule
bind fbp_host fbp_sva fbp_sva_i (.i_sys_clk, .i_sys_rst, .i_powerdown, .o_busy, .o_addr_in,
   .o_addr_line_nine_signature_sel, .o_data_io, .o_data_io_oe_n, .o_chip_sel_n,
   .o_out_en_n, .o_write_strobe_n, .o_reset_powerdown_n);

// ### tb/fbp_flash_model.sv
// Behavioural model of the byte-wide boot-block flash on the far side.
`timescale 1ns/10ps
module fbp_flash_model
#(
   parameter logic [7:0] PGM_CMD = 8'h40,
   parameter logic [7:0] MAKER = 8'h5a, // Arbitrary value.
   parameter logic [7:0] PART = 8'ha5, // Arbitrary value.
   parameter logic VPP_OK = 1'b1
)
(
   // Flash pins.
   input logic [17:0] i_addr_in,
   input logic i_sig,
   input logic [7:0] i_data,
   input logic i_cs_n,
   input logic i_oe_n,
   input logic i_we_n,
   input logic i_rp_n,
   input logic i_unlock,
   output logic [7:0] o_data
);
   logic [7:0] mem [16];
   logic armed;
   logic [7:0] rd;
   logic boot;
   initial foreach (mem[k]) mem[k] = 8'hff;
   // Only the low four address bits are kept, so places alias; tests avoid that.
   assign boot = i_addr_in[17:14] == 4'h0;
   assign rd = i_sig ? (i_addr_in[0] ? PART : MAKER) : mem[i_addr_in[3:0]];
   // Released pins show a moving inverse value so a stale read cannot match.
   assign o_data = (!i_cs_n && !i_oe_n && i_rp_n) ? rd : ~rd;
   // Latch on the strobe rising edge; the second write of a program stores data unless the boot block is locked.
   always @(posedge i_we_n or negedge i_rp_n)
      if (!i_rp_n)
         armed <= 1'b0;
      else if (!i_cs_n)
      begin
         if (armed && VPP_OK && (!boot || i_unlock))
            mem[i_addr_in[3:0]] <= i_data;
         armed <= !armed && i_data == PGM_CMD;
      end
endmodule

// ### tb/flash_byte_bus_port_bench.sv
// Self-checking bench for the flash byte bus host controller.
`timescale 1ns/10ps
module flash_byte_bus_port_bench;
   import fbp_pkg::*;
   // ----------------------------------------
   // Signals and instances
   // ----------------------------------------
   logic clk = 1'b0, rst = 1'b1, req = 1'b0, unl = 1'b0, pd = 1'b0;
   fbp_op_t op = FBP_OP_READ;
   logic [17:0] addr = 18'h0, a_pin;
   logic [7:0] wd = 8'h0, cmd = 8'h0, rdata, d_out, d_in, dev_q;
   logic busy, done, sig, doe_n, cs_n, oe_n, we_n, rp_n, rp_unl;
   int mismatches = 0, n_tests = 0, cycles = 0;
   // The data wire carries whichever side has its drivers on.
   assign d_in = !doe_n ? d_out : dev_q;
   fbp_host fbp_host_i (.i_sys_clk(clk), .i_sys_rst(rst), .i_req(req), .i_op(op),
      .i_addr(addr), .i_wdata(wd), .i_cmd(cmd), .i_boot_unlock(unl), .i_powerdown(pd),
      .o_busy(busy), .o_done(done), .o_rdata(rdata), .o_addr_in(a_pin),
      .o_addr_line_nine_signature_sel(sig), .o_data_io(d_out), .o_data_io_oe_n(doe_n),
      .i_data_io(d_in), .o_chip_sel_n(cs_n), .o_out_en_n(oe_n), .o_write_strobe_n(we_n),
      .o_reset_powerdown_n(rp_n), .o_reset_powerdown_unlock(rp_unl));
   fbp_flash_model fbp_flash_model_i (.i_addr_in(a_pin), .i_sig(sig), .i_data(d_in),
      .i_cs_n(cs_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_rp_n(rp_n), .i_unlock(rp_unl),
      .o_data(dev_q));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic stop_test();
      if (mismatches == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // One request, held until taken, then a bounded wait for its done pulse.
   task automatic xfer(input fbp_op_t o, input logic [17:0] a, input logic [7:0] c);
      int k;
      @(posedge clk) #5;
      op = o;
      addr = a;
      cmd = c;
      req = 1'b1;
      for (k = 0; k < 3 && busy !== 1'b1; k++) @(posedge clk) #5;
      req = 1'b0;
      for (k = 0; k < 12 && done !== 1'b1; k++) @(posedge clk) #5;
      chk("done", {7'h0, done}, 8'h01);
   endtask
   task automatic t_prog(input logic [17:0] a, input logic [7:0] d, exp, input logic u);
      unl = u;
      wd = d;
      xfer(FBP_OP_PROGRAM, a, 8'h40);
      xfer(FBP_OP_READ, a, 8'h0);
      chk("array", rdata, exp);
      unl = 1'b0;
   endtask
   // A command other than program must not make the next byte land in the array.
   task automatic t_cmd();
      xfer(FBP_OP_WRITE, 18'h2000b, 8'hff);
      xfer(FBP_OP_WRITE, 18'h2000b, 8'h11);
      xfer(FBP_OP_READ, 18'h2000b, 8'h0);
      chk("cmd", rdata, 8'hff);
   endtask
   task automatic t_sig();
      xfer(FBP_OP_SIGNATURE, 18'h0, 8'h0);
      chk("maker", rdata, 8'h5a);
      xfer(FBP_OP_SIGNATURE, 18'h1, 8'h0);
      chk("part", rdata, 8'ha5);
   endtask
   // Power-down between the program setup and its data cancels the program.
   task automatic t_pd();
      xfer(FBP_OP_WRITE, 18'h20003, 8'h40);
      pd = 1'b1;
      req = 1'b1;
      repeat (4) @(posedge clk) #5;
      chk("rp_n", {7'h0, rp_n}, 8'h00);
      chk("busy", {7'h0, busy}, 8'h00);
      pd = 1'b0;
      req = 1'b0;
      repeat (2) @(posedge clk) #5;
      chk("rp_n", {7'h0, rp_n}, 8'h01);
      xfer(FBP_OP_WRITE, 18'h20003, 8'h77);
      xfer(FBP_OP_READ, 18'h20003, 8'h0);
      chk("wake", rdata, 8'h3c);
   endtask
   // ----------------------------------------
   // Clock, timeout and main sequence
   // ----------------------------------------
   initial forever #25 clk = ~clk;
   // A run of some fifteen transfers needs a few hundred cycles at most.
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         mismatches++;
         stop_test();
      end
   end
   initial
   begin
      repeat (3) @(posedge clk);
      #5 rst = 1'b0;
      xfer(FBP_OP_READ, 18'h20003, 8'h0);
      chk("erased", rdata, 8'hff);
      t_prog(18'h20003, 8'h3c, 8'h3c, 1'b0);
      t_prog(18'h00007, 8'h5a, 8'hff, 1'b0);
      t_prog(18'h00007, 8'h5a, 8'h5a, 1'b1);
      t_cmd();
      t_sig();
      t_pd();
      stop_test();
   end
endmodule
